// ===== rtl/mode_word_block.sv
`timescale 1ns/100ps
`include "mode_word_regs.svh"
// Summary of operation
// - all three strobes low load address word
// - programming busy for two clocks
// - bits 2..0 give burst length
// - full page is 512 columns, wraps
// - bit 3 selects sequential or interleaved
// - sequential counts modulo burst length
// - interleaved is start xor beat count
// - bits 6..4 give read latency
// - latency delays first read data
// - bit 9 selects single word writes
module mode_word_block
  import mode_word_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic [12:0] addr_pin,
  input wire logic read_cmd,
  input wire logic burst_start,
  input wire logic burst_write,
  input wire logic [8:0] start_col,
  output mode_cfg_s cfg,
  output logic prog_busy,
  output logic mode_valid,
  output logic [8:0] burst_col,
  output logic burst_active,
  output logic read_data_go
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any decode
  cmd_s cmd_m_q;
  cmd_s cmd_s_q;
  logic [12:0] addr_m_q;
  logic [12:0] addr_s_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cmd_m_q <= '1;
      cmd_s_q <= '1;
      addr_m_q <= 13'h0000;
      addr_s_q <= 13'h0000;
    end else begin
      cmd_m_q <= '{ras_n_pin, cas_n_pin, we_n_pin};
      cmd_s_q <= cmd_m_q;
      addr_m_q <= addr_pin;
      addr_s_q <= addr_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command decode and programming sequencer
  wire prog_cmd = !cmd_s_q.ras_n && !cmd_s_q.cas_n && !cmd_s_q.we_n;
  prog_state_e state_q;
  prog_state_e state_d;
  logic [12:0] operating_mode_word_q; // latched mode word
  logic valid_q;

  // the busy window hides a second write; controller must wait anyway
  always_comb begin
    state_d = state_q;
    case (state_q)
      PROG_IDLE: begin
        if (prog_cmd) begin
          state_d = PROG_BUSY1;
        end
      end
      PROG_BUSY1: state_d = PROG_BUSY2;
      PROG_BUSY2: state_d = PROG_IDLE;
      default: state_d = PROG_IDLE;
    endcase
  end

  // word taken on the command edge; valid stays low until first write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= PROG_IDLE;
      operating_mode_word_q <= `MODE_RESET;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (prog_cmd && state_q == PROG_IDLE) begin
        operating_mode_word_q <= addr_s_q;
        valid_q <= 1'b1;
      end
    end
  end

  assign prog_busy = (state_q != PROG_IDLE);
  assign mode_valid = valid_q;

  ////////////////////////////////////////////////////////////////////
  // field decode
  wire [2:0] blen_code = operating_mode_word_q[`BLEN_MSB:`BLEN_LSB];
  wire [2:0] lat_code = operating_mode_word_q[`LAT_MSB:`LAT_LSB];
  wire order_bit = operating_mode_word_q[`ORDER_BIT];
  wire wb_bit = operating_mode_word_q[`WBURST_BIT];
  wire [1:0] test_bits = operating_mode_word_q[`TEST_MSB:`TEST_LSB];
  logic [9:0] blen;
  logic blen_bad;

  // burst length table; reserved codes fall back to one
  always_comb begin
    blen_bad = 1'b0;
    case (blen_code)
      `BLEN_1: blen = 10'h001;
      `BLEN_2: blen = 10'h002;
      `BLEN_4: blen = 10'h004;
      `BLEN_8: blen = 10'h008;
      `BLEN_PAGE: blen = 10'h200;
      default: begin
        blen = 10'h001;
        blen_bad = 1'b1;
      end
    endcase
  end

  wire lat_bad = (lat_code != `LAT_2) && (lat_code != `LAT_3);
  wire order_bad = order_bit && (blen_code != `BLEN_4) && (blen_code != `BLEN_8);
  wire page = (blen_code == `BLEN_PAGE);

  assign cfg.burst_len = blen;
  assign cfg.burst_order_select = order_bit;
  assign cfg.read_latency = (lat_code == `LAT_3) ? 2'h3 : 2'h2;
  assign cfg.write_burst_select = wb_bit;
  assign cfg.full_page = page;
  assign cfg.code_error = blen_bad || lat_bad || order_bad || (test_bits != 2'h0);

  ////////////////////////////////////////////////////////////////////
  // column sequence generator
  logic [8:0] base_q; // starting column
  logic [8:0] beat_q; // beat count
  logic [9:0] left_q; // beats remaining
  logic active_q;
  wire [8:0] mask = blen[8:0] - 9'h001; // low-bit mask per length
  wire [8:0] seq_col = (base_q & ~mask) | ((base_q + beat_q) & mask);
  wire [8:0] ilv_col = (base_q & ~mask) | ((base_q ^ beat_q) & mask);
  wire single = burst_write && wb_bit;
  wire [9:0] start_len = single ? 10'h001 : blen;

  // full page, except a single write, never ends by count; it runs until the next start
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      base_q <= 9'h000;
      beat_q <= 9'h000;
      left_q <= 10'h000;
      active_q <= 1'b0;
    end else if (burst_start) begin
      base_q <= start_col;
      beat_q <= 9'h000;
      left_q <= start_len;
      active_q <= 1'b1;
    end else if (active_q) begin
      beat_q <= beat_q + 9'h001;
      if (!(page && !single)) begin
        left_q <= left_q - 10'h001;
        active_q <= (left_q != 10'h001);
      end
    end
  end

  // page wrap: 9-bit mask of 1FF makes the adder wrap 511 to 0
  wire [8:0] col_d = order_bit ? ilv_col : seq_col;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      burst_col <= 9'h000;
    end else begin
      burst_col <= col_d;
    end
  end
  assign burst_active = active_q;

  ////////////////////////////////////////////////////////////////////
  // read latency pipe: first data strobe latency clocks after the read
  logic [2:0] rd_pipe_q;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_pipe_q <= 3'h0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[1:0], read_cmd};
    end
  end
  assign read_data_go = (cfg.read_latency == 2'h3) ? rd_pipe_q[2] : rd_pipe_q[1];

  ////////////////////////////////////////////////////////////////////
  // assertions
  AST_PROG_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (prog_cmd && !prog_busy) |=> (operating_mode_word_q == $past(addr_s_q)))
    else $error("mode word not loaded");
  AST_BUSY_TWO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (prog_cmd && !prog_busy) |=> prog_busy [*2] ##1 !prog_busy)
    else $error("busy window not two clocks");
  AST_BLEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (blen_code == `BLEN_8) |-> (cfg.burst_len == 10'h008))
    else $error("burst length decode wrong");
  AST_ORDER: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg.burst_order_select == operating_mode_word_q[3])
    else $error("order bit wrong");
  AST_LAT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (lat_code == `LAT_3) |-> (cfg.read_latency == 2'h3))
    else $error("latency decode wrong");
  AST_RD3: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (read_cmd && cfg.read_latency == 2'h3 && !prog_busy) ##1 !prog_busy [*3] |-> read_data_go)
    else $error("read data not at latency three");
  AST_SEQ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (active_q && !order_bit) |=> (burst_col == $past(seq_col)))
    else $error("sequential column wrong");
  AST_SINGLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (burst_start && burst_write && wb_bit) |=> ##1 !burst_active || burst_start)
    else $error("single write burst too long");
  AST_ERR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode_valid && blen_code == 3'h4) |-> cfg.code_error)
    else $error("reserved code not flagged");
  COV_PROG: cover property (@(posedge clk_sys) prog_cmd && !prog_busy);
  COV_ILV: cover property (@(posedge clk_sys) active_q && order_bit && blen_code == `BLEN_8);
  COV_PAGE: cover property (@(posedge clk_sys) active_q && page && beat_q == `PAGE_LAST);

endmodule

// ===== rtl/mode_word_pkg.sv
package mode_word_pkg;
  // command pins, all active low
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_s;
  // decoded settings handed to the rest of the device
  typedef struct packed {
    logic [9:0] burst_len;
    logic burst_order_select;
    logic [1:0] read_latency;
    logic write_burst_select;
    logic full_page;
    logic code_error;
  } mode_cfg_s;
  typedef enum logic [1:0] {
    PROG_IDLE = 2'h0,
    PROG_BUSY1 = 2'h1,
    PROG_BUSY2 = 2'h3
  } prog_state_e;
endpackage

// ===== rtl/mode_word_regs.svh
`ifndef MODE_WORD_REGS_SVH
`define MODE_WORD_REGS_SVH
// field positions of the operating mode word
`define BLEN_LSB 0
`define BLEN_MSB 2
`define ORDER_BIT 3
`define LAT_LSB 4
`define LAT_MSB 6
`define TEST_LSB 7
`define TEST_MSB 8
`define WBURST_BIT 9
// field codes
`define BLEN_1 3'h0
`define BLEN_2 3'h1
`define BLEN_4 3'h2
`define BLEN_8 3'h3
`define BLEN_PAGE 3'h7
`define LAT_2 3'h2
`define LAT_3 3'h3
// reset values of the latched word (all zero; mode_valid stays low until programmed)
`define MODE_RESET 13'h0000
// programming write busy time, in clocks
`define PROG_CYCLES 2'h2
// full page column count minus one
`define PAGE_LAST 9'h1FF
`endif

// ===== tb/mode_ctrl_model.sv
`timescale 1ns/100ps
// stands in for the memory controller on the command and address pins
module mode_ctrl_model (
  input wire logic clk_sys,
  output logic ras_n_pin,
  output logic cas_n_pin,
  output logic we_n_pin,
  output logic [12:0] addr_pin
);
  logic [12:0] last_q; // last word put on the pins
  // pins idle as a no-op until the first programming cycle
  initial begin
    {ras_n_pin, cas_n_pin, we_n_pin} = 3'h7;
    addr_pin = 13'h0000;
    last_q = 13'h0000;
  end
  //////////////////////////////////////////
  // one programming cycle, then a no-op; the caller only asks when all banks are idle
  task automatic prog(input logic [12:0] word, input int gap);
    @(negedge clk_sys);
    {ras_n_pin, cas_n_pin, we_n_pin} = 3'h0;
    last_q = word & 13'h1BFF;
    addr_pin = last_q;
    @(negedge clk_sys);
    {ras_n_pin, cas_n_pin, we_n_pin} = 3'h7;
    // released pins show the inverse, so a stale word can never pass
    addr_pin = ~last_q;
    repeat (gap) @(negedge clk_sys);
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
  import mode_word_pkg::*;
  logic clk_sys = 0, reset_n = 0, read_cmd = 0, burst_start = 0, burst_write = 0, act_d = 0;
  logic ras_n_pin, cas_n_pin, we_n_pin, prog_busy, mode_valid, burst_active, read_data_go;
  logic [12:0] addr_pin, w;
  logic [8:0] start_col = 0, burst_col;
  mode_cfg_s cfg, e;
  int n_mismatch = 0, check_count = 0, seed = 32'hD4F9D853, n, k;
  logic [15:0] exp_q[$]; // columns still owed by the running burst
  // test and reserved codes are sent on purpose to see them flagged
  logic [12:0] words[10] = '{13'h0020, 13'h0031, 13'h002A, 13'h003B, 13'h0222,
    13'h0024, 13'h0000, 13'h0029, 13'h00A2, 13'h0027};
  always #25 clk_sys = ~clk_sys;
  mode_ctrl_model u_ctrl (.clk_sys(clk_sys), .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin),
    .we_n_pin(we_n_pin), .addr_pin(addr_pin));
  mode_word_block u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .ras_n_pin(ras_n_pin),
    .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .addr_pin(addr_pin), .read_cmd(read_cmd),
    .burst_start(burst_start), .burst_write(burst_write), .start_col(start_col), .cfg(cfg),
    .prog_busy(prog_busy), .mode_valid(mode_valid), .burst_col(burst_col),
    .burst_active(burst_active), .read_data_go(read_data_go));
  //////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] xp);
    check_count++;
    if (seen !== xp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, xp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // expected decode of a word, worked out independently
  function automatic mode_cfg_s xcfg(logic [12:0] wd);
    mode_cfg_s r;
    logic br, lr;
    br = wd[2:0] inside {3'h4, 3'h5, 3'h6};
    lr = wd[6:4] != 3'h2 && wd[6:4] != 3'h3;
    r.burst_len = br ? 10'h001 : (wd[2:0] == 3'h7) ? 10'h200 : 10'h001 << wd[2:0];
    r.burst_order_select = wd[3];
    r.read_latency = (wd[6:4] == 3'h3) ? 2'h3 : 2'h2;
    r.write_burst_select = wd[9];
    r.full_page = wd[2:0] == 3'h7;
    r.code_error = br | lr | (wd[3] & !(wd[2:0] inside {3'h2, 3'h3})) | (wd[8:7] != 2'h0);
    return r;
  endfunction
  // program a word and count the busy cycles after it
  task automatic pw(logic [12:0] wd, int gap);
    n = 0;
    fork
      u_ctrl.prog(wd, gap);
      repeat (8) @(negedge clk_sys) n += (prog_busy === 1'b1);
    join
    chk("busy_cycles", 16'(n), 16'h0002);
    chk("mode_valid", 16'(mode_valid), 16'h0001);
  endtask
  //////////////////////////////////////////
  // start a burst at a random column and note each column it must visit;
  // a page burst is noted for eight beats only, so it has to come last
  task automatic burst(logic [12:0] wd);
    logic [9:0] len;
    logic [8:0] msk, s;
    len = (wd[9] && burst_write) ? 10'h001 : e.burst_len;
    msk = 9'(len - 10'h001);
    s = 9'($random(seed));
    for (k = 0; k < len && k < 8; k++)
      exp_q.push_back({7'h00, (s & ~msk) | ((wd[3] ? s ^ 9'(k) : s + 9'(k)) & msk)});
    start_col = s;
    burst_start = 1;
    @(negedge clk_sys);
    burst_start = 0;
    start_col = ~s; // the column is only sampled with the start pulse
    for (n = 0; n < 40 && exp_q.size() > 0; n++) @(negedge clk_sys);
    if (exp_q.size() > 0) begin
      n_mismatch++;
      close_out();
    end
    // a counted burst must have stopped once its last column was seen
    if (len != 10'h200) chk("burst_active", 16'(burst_active), 16'h0000);
  endtask
  // count cycles from a read command to the data strobe
  task automatic rd(logic [1:0] lat);
    read_cmd = 1;
    @(negedge clk_sys);
    read_cmd = 0;
    // this negedge already follows the edge that took the read, so it counts as one
    for (n = 1; n < 9 && read_data_go !== 1'b1; n++) @(negedge clk_sys);
    chk("read_lat", 16'(n), 16'(lat));
  endtask
  // burst_col lags a beat, so compare while the previous sample saw the burst
  always @(negedge clk_sys) begin
    if (act_d && exp_q.size() > 0) chk("burst_col", {7'h00, burst_col}, exp_q.pop_front());
    act_d = burst_active;
  end
  //////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk_sys);
    chk("mode_valid", 16'(mode_valid), 16'h0000);
    chk("prog_busy", 16'(prog_busy), 16'h0000);
    reset_n = 1;
    // a second command inside the busy window must be ignored
    u_ctrl.prog(13'h0023, 0);
    pw(13'h0021, 6);
    chk("cfg", cfg, xcfg(13'h0023));
    $display("test refuse done");
    foreach (words[i]) begin
      burst_write = 1'($random(seed));
      w = {2'($random(seed)), words[i][10:0]}; // bits 12:11 carry noise
      e = xcfg(w);
      pw(w, 6);
      chk("cfg", cfg, e);
      if (!e.code_error) burst(w);
      rd(e.read_latency);
      $display("test word %h done", w);
    end
    close_out();
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end
endmodule
